// file: bench/dwdt_dev_model.sv
`timescale 1ns/1ps
// One watchdog of the board: restarts on a low kick pin, pulses on expiry
module dwdt_dog_model #(
  parameter int TIMEOUT = 100,
  parameter int PULSE = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Kick pin level and outputs
  input wire logic kick_pin,
  output logic reset_drain_out,
  output logic pulse_out
);
  int cnt; // Cycles since the last restart
  int pul; // Pulse cycles left
  // Timing and pulse counters; reset stands for power-up
  always_ff @(posedge sys_clk) begin
    if (!rst_b || kick_pin === 1'b0) begin
      cnt <= 0;
      pul <= 0;
    end else if (pul != 0) begin // Pulse runs out, then timing restarts
      pul <= pul - 1;
    end else if (cnt == TIMEOUT - 1) begin // Expiry starts the pulse
      cnt <= 0;
      pul <= PULSE;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Drain released and pulse low while kicked in time
  assign reset_drain_out = (pul == 0);
  assign pulse_out = (pul != 0);
endmodule

// Both watchdogs, each with its own pin, timeout and outputs
module dwdt_dev_model #(
  parameter int TO1 = 100,
  parameter int TO2 = 60,
  parameter int PULSE = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Kick pin levels
  input wire logic wd1_kick_pin,
  input wire logic wd2_kick_pin,
  // Outputs to the host
  output logic wd1_reset_drain_out,
  output logic wd2_reset_drain_out,
  output logic wd1_pulse_out,
  output logic wd2_pulse_out
);
  // Independent channels; in cascade the gap is the timeout difference
  dwdt_dog_model #(.TIMEOUT(TO1), .PULSE(PULSE)) i_first_watchdog (.sys_clk(sys_clk), .rst_b(rst_b),
    .kick_pin(wd1_kick_pin), .reset_drain_out(wd1_reset_drain_out), .pulse_out(wd1_pulse_out));
  dwdt_dog_model #(.TIMEOUT(TO2), .PULSE(PULSE)) i_second_watchdog (.sys_clk(sys_clk), .rst_b(rst_b),
    .kick_pin(wd2_kick_pin), .reset_drain_out(wd2_reset_drain_out), .pulse_out(wd2_pulse_out));
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [39:0] LOW = 40'h8; // Shortened kick low time
  localparam int TO1 = 100; // Scaled timeouts, first longer
  localparam int TO2 = 60;
  logic sys_clk, rst_b, wd1_enable, wd2_enable, cascade_mode, buffered_mode;
  logic wd1_kick_now, wd2_kick_now, wd1_kick_o, wd1_kick_oe, wd2_kick_o, wd2_kick_oe;
  logic wd1_rst_d, wd2_rst_d, wd1_pul, wd2_pul, wd1_expired, wd2_expired;
  logic wd1_kicking, wd2_kicking;
  logic [39:0] pulse_gap;
  wire logic wd1_pin = wd1_kick_oe ? wd1_kick_o : 1'b1; // Pulled up when floated
  wire logic wd2_pin = wd2_kick_oe ? wd2_kick_o : 1'b1;
  int bad_count, n_compared, cycles, w, n;
  // Host under test
  dwdt_host #(.KICK_LOW_CYC(LOW), .KICK_PERIOD_CYC(40'h28), .PULSE_CYC(40'ha)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .wd1_enable(wd1_enable), .wd2_enable(wd2_enable),
    .cascade_mode(cascade_mode), .buffered_mode(buffered_mode), .wd1_kick_now(wd1_kick_now),
    .wd2_kick_now(wd2_kick_now), .wd1_kick_in(wd1_pin), .wd1_kick_o(wd1_kick_o),
    .wd1_kick_oe(wd1_kick_oe), .wd2_kick_in(wd2_pin), .wd2_kick_o(wd2_kick_o),
    .wd2_kick_oe(wd2_kick_oe), .wd1_reset_drain_out(wd1_rst_d), .wd2_reset_drain_out(wd2_rst_d),
    .wd1_pulse_out(wd1_pul), .wd2_pulse_out(wd2_pul), .wd1_expired(wd1_expired),
    .wd2_expired(wd2_expired), .wd1_kicking(wd1_kicking), .wd2_kicking(wd2_kicking),
    .pulse_gap(pulse_gap));
  // Watchdog board model
  dwdt_dev_model #(.TO1(TO1), .TO2(TO2), .PULSE(10)) i_dev (.sys_clk(sys_clk), .rst_b(rst_b),
    .wd1_kick_pin(wd1_pin), .wd2_kick_pin(wd2_pin), .wd1_reset_drain_out(wd1_rst_d),
    .wd2_reset_drain_out(wd2_rst_d), .wd1_pulse_out(wd1_pul), .wd2_pulse_out(wd2_pul));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end
  // Compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset with all controls off
  task automatic do_reset();
    rst_b <= 1'b0;
    {wd1_enable, wd2_enable, cascade_mode, buffered_mode, wd1_kick_now, wd2_kick_now} <= '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    check({wd1_kick_oe, wd2_kick_oe, wd1_expired, wd2_expired}, 40'h0);
  endtask
  // Wait for one channel's low phase and measure it
  task automatic kick_shape(input logic buf_m);
    buffered_mode <= buf_m;
    wd1_enable <= 1'b1;
    for (w = 0; w < 60 && !(wd1_kick_oe === 1'b1 && wd1_kick_o === 1'b0); w++) begin
      @(posedge sys_clk);
      #1;
    end
    for (n = 0; n < 100 && wd1_kick_oe === 1'b1 && wd1_kick_o === 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check(n, LOW);
    check({wd1_kick_oe, wd1_kick_o}, {buf_m, buf_m});
  endtask
  // Regular kicks keep both outputs idle
  task automatic keep_alive();
    wd2_enable <= 1'b1;
    n = 0;
    repeat (400) begin
      @(posedge sys_clk);
      #1;
      if (wd1_pul || wd2_pul || !wd1_rst_d || !wd2_rst_d || wd1_expired || wd2_expired) n++;
    end
    check(n, 0);
  endtask
  // First channel left alone while the second is kicked on demand
  task automatic independent_expiry();
    wd1_enable <= 1'b0;
    wd2_enable <= 1'b0;
    for (w = 0; w < 300 && wd1_expired !== 1'b1; w++) begin
      wd2_kick_now <= (w % 40 == 0);
      @(posedge sys_clk);
      #1;
    end
    wd2_kick_now <= 1'b0;
    check({wd1_expired, wd2_expired}, 40'h2);
    wd1_kick_now <= 1'b1;
    @(posedge sys_clk);
    wd1_kick_now <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    check(wd1_expired, 1'b0);
  endtask
  // Both channels kicked together, then left to expire
  task automatic cascade();
    do_reset();
    cascade_mode <= 1'b1;
    wd1_enable <= 1'b1;
    for (w = 0; w < 10 && wd1_kick_oe !== 1'b1; w++) begin
      @(posedge sys_clk);
      #1;
    end
    check({wd1_kicking, wd2_kicking, wd1_kick_oe, wd1_kick_o, wd2_kick_oe, wd2_kick_o}, 40'h3a);
    wd1_enable <= 1'b0;
    for (w = 0; w < 400 && wd1_expired !== 1'b1; w++) begin
      @(posedge sys_clk);
      #1;
    end
    repeat (3) @(posedge sys_clk);
    #1;
    check({wd1_expired, wd2_expired}, 40'h3);
    check(pulse_gap, 40'(TO1 - TO2));
    wd1_enable <= 1'b1;
    repeat (200) @(posedge sys_clk);
    #1;
    check({wd1_expired, wd2_expired}, 40'h0);
  endtask
  // Main sequence
  initial begin
    {rst_b, wd1_enable, wd2_enable, cascade_mode, buffered_mode} = '0;
    {wd1_kick_now, wd2_kick_now} = '0;
    do_reset();
    kick_shape(1'b0);
    kick_shape(1'b1);
    keep_alive();
    independent_expiry();
    cascade();
    complete_run();
  end
endmodule

// file: src/dwdt_host.sv
`timescale 1ns/1ps
module dwdt_host #(
  parameter logic [39:0] KICK_LOW_CYC = 40'(dwdt_pkg::KICK_LOW_CYC),
  parameter logic [39:0] KICK_PERIOD_CYC = 40'(64'(dwdt_pkg::CLK_HZ) * dwdt_pkg::KICK_PERIOD_S),
  parameter logic [39:0] PULSE_CYC = 40'(dwdt_pkg::EXPIRY_PULSE_CYC)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host controls
  input wire logic wd1_enable,
  input wire logic wd2_enable,
  input wire logic cascade_mode,
  input wire logic buffered_mode,
  input wire logic wd1_kick_now,
  input wire logic wd2_kick_now,
  // Kick pins, three signals each
  input wire logic wd1_kick_in,
  output logic wd1_kick_o,
  output logic wd1_kick_oe,
  input wire logic wd2_kick_in,
  output logic wd2_kick_o,
  output logic wd2_kick_oe,
  // Device outputs observed
  input wire logic wd1_reset_drain_out,
  input wire logic wd2_reset_drain_out,
  input wire logic wd1_pulse_out,
  input wire logic wd2_pulse_out,
  // Status to host logic
  output logic wd1_expired,
  output logic wd2_expired,
  output logic wd1_kicking,
  output logic wd2_kicking,
  output logic [39:0] pulse_gap
);
  // Cascade joins both kicks into one; lockstep holds only if
  // both kickers are idle when cascade is entered
  logic k2_enable, k2_now;
  assign k2_enable = cascade_mode ? wd1_enable : wd2_enable;
  assign k2_now = cascade_mode ? wd1_kick_now : wd2_kick_now;

  // First channel kicker
  dwdt_kicker #(.CNT_W(dwdt_pkg::CNT_W), .LOW_CYC(KICK_LOW_CYC), .PERIOD_CYC(KICK_PERIOD_CYC))
  u_k1 (
    .sys_clk(sys_clk), .rst_b(rst_b), .enable(wd1_enable), .kick_now(wd1_kick_now),
    .buffered_drive_high(buffered_mode),
    .kick_in(wd1_kick_in), .kick_o(wd1_kick_o), .kick_oe(wd1_kick_oe),
    .kick_busy(wd1_kicking)
  );
  // Second channel kicker; lockstep with first in cascade
  dwdt_kicker #(.CNT_W(dwdt_pkg::CNT_W), .LOW_CYC(KICK_LOW_CYC), .PERIOD_CYC(KICK_PERIOD_CYC))
  u_k2 (
    .sys_clk(sys_clk), .rst_b(rst_b), .enable(k2_enable), .kick_now(k2_now),
    .buffered_drive_high(buffered_mode),
    .kick_in(wd2_kick_in), .kick_o(wd2_kick_o), .kick_oe(wd2_kick_oe),
    .kick_busy(wd2_kicking)
  );

  // Expiry detection and cascade gap measure
  logic p1_d_reg, p1_d_next, p2_d_reg, p2_d_next;
  logic e1_reg, e1_next, e2_reg, e2_next;
  logic gap_run_reg, gap_run_next;
  logic [39:0] gap_cnt_reg, gap_cnt_next;
  logic [39:0] gap_reg, gap_next;
  logic expiry1, expiry2;

  // An expiry is a rising pulse or a reset pulled low
  assign expiry1 = wd1_pulse_out || !wd1_reset_drain_out;
  assign expiry2 = wd2_pulse_out || !wd2_reset_drain_out;

  // Next values: sticky expiry flags cleared by a new kick, gap timer
  always_comb begin
    p1_d_next = expiry1;
    p2_d_next = expiry2;
    e1_next = e1_reg;
    e2_next = e2_reg;
    if (wd1_kicking) begin
      e1_next = 1'b0;
    end
    if (wd2_kicking) begin
      e2_next = 1'b0;
    end
    // Set wins over clear
    if (expiry1 && !p1_d_reg) begin
      e1_next = 1'b1;
    end
    if (expiry2 && !p2_d_reg) begin
      e2_next = 1'b1;
    end
    gap_run_next = gap_run_reg;
    gap_cnt_next = gap_cnt_reg;
    gap_next = gap_reg;
    if (cascade_mode && expiry2 && !p2_d_reg) begin
      // Shorter second timer expires first: start measuring there
      gap_run_next = 1'b1;
      gap_cnt_next = 40'h1;
    end else if (gap_run_reg) begin
      if (expiry1 && !p1_d_reg) begin
        // First timer's pulse: record spacing edge to edge
        gap_run_next = 1'b0;
        gap_next = gap_cnt_reg;
      end else begin
        gap_cnt_next = gap_cnt_reg + 40'h1;
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      p1_d_reg <= 1'b0;
      p2_d_reg <= 1'b0;
      e1_reg <= 1'b0;
      e2_reg <= 1'b0;
      gap_run_reg <= 1'b0;
      gap_cnt_reg <= 40'h0;
      gap_reg <= 40'h0;
    end else begin
      p1_d_reg <= p1_d_next;
      p2_d_reg <= p2_d_next;
      e1_reg <= e1_next;
      e2_reg <= e2_next;
      gap_run_reg <= gap_run_next;
      gap_cnt_reg <= gap_cnt_next;
      gap_reg <= gap_next;
    end
  end

  assign wd1_expired = e1_reg;
  assign wd2_expired = e2_reg;
  assign pulse_gap = gap_reg;

  // Cascade kicks both pins together
  AST_CASCADE_SYNC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cascade_mode && $rose(wd1_kicking) && $stable(cascade_mode))
    |-> wd2_kicking || $past(wd2_kicking))
    else $error("cascade kicks apart");
  // Expiry flag set one cycle after an expiry edge
  AST_EXP_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (expiry1 && !p1_d_reg) |=> wd1_expired) else $error("expiry missed");
  // Gap capture takes the counted value at the first timer's edge
  AST_GAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (gap_run_reg && expiry1 && !p1_d_reg && !(cascade_mode && expiry2 && !p2_d_reg))
    |=> pulse_gap == $past(gap_cnt_reg)) else $error("gap wrong");
  // Idle second kick pin never driven in unbuffered mode
  AST_IDLE_PIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!wd2_kicking && !buffered_mode && $stable(buffered_mode)) |-> !wd2_kick_oe)
    else $error("pin driven idle");
  COV_EXP: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(wd1_expired));
  COV_CASC: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(gap_run_reg));
  COV_BUF: cover property (@(posedge sys_clk) disable iff (!rst_b) buffered_mode && wd1_kicking);
endmodule

// file: src/dwdt_kicker.sv
`timescale 1ns/1ps
// One kick channel: drives the kick pin low for a fixed time, then floats it, or drives it high on the buffered header
module dwdt_kicker #(
  parameter int unsigned CNT_W = 40,
  parameter logic [39:0] LOW_CYC = 40'h00004c4b40,
  parameter logic [39:0] PERIOD_CYC = 40'h001dcd6500
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic kick_now,
  input wire logic buffered_drive_high,
  // Kick pin, three signals
  input wire logic kick_in,
  output logic kick_o,
  output logic kick_oe,
  // Status
  output logic kick_busy
);
  // State and counter
  dwdt_pkg::dwdt_kick_state_t state_reg, state_next;
  logic [39:0] cnt_reg, cnt_next;
  logic kick_o_reg, kick_o_next;
  logic kick_oe_reg, kick_oe_next;

  // Next state: low phase, then release, then wait out the period
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    kick_o_next = 1'b0;
    kick_oe_next = 1'b0;
    unique case (state_reg)
      dwdt_pkg::DWDT_IDLE: begin
        // Released pin: float, or drive high on the buffered header
        kick_o_next = buffered_drive_high;
        kick_oe_next = buffered_drive_high;
        // Kicking resumes on the first edge after a reset when enabled
        if (enable || kick_now) begin
          state_next = dwdt_pkg::DWDT_LOW;
          cnt_next = LOW_CYC - 40'h1;
          kick_o_next = 1'b0;
          kick_oe_next = 1'b1;
        end
      end
      dwdt_pkg::DWDT_LOW: begin
        kick_o_next = 1'b0;
        kick_oe_next = 1'b1;
        if (cnt_reg == 40'h0) begin
          // Release after the low time
          state_next = dwdt_pkg::DWDT_WAIT;
          cnt_next = PERIOD_CYC - LOW_CYC - 40'h1;
          kick_o_next = buffered_drive_high;
          kick_oe_next = buffered_drive_high;
        end else begin
          cnt_next = cnt_reg - 40'h1;
        end
      end
      dwdt_pkg::DWDT_WAIT: begin
        kick_o_next = buffered_drive_high;
        kick_oe_next = buffered_drive_high;
        if (kick_now) begin
          state_next = dwdt_pkg::DWDT_LOW;
          cnt_next = LOW_CYC - 40'h1;
          kick_o_next = 1'b0;
          kick_oe_next = 1'b1;
        end else if (cnt_reg == 40'h0) begin
          // Period over, kick again well before the timeout
          state_next = dwdt_pkg::DWDT_IDLE;
        end else begin
          cnt_next = cnt_reg - 40'h1;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= dwdt_pkg::DWDT_IDLE;
      cnt_reg <= 40'h0;
      kick_o_reg <= 1'b0;
      kick_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      kick_o_reg <= kick_o_next;
      kick_oe_reg <= kick_oe_next;
    end
  end

  assign kick_o = kick_o_reg;
  assign kick_oe = kick_oe_reg;
  assign kick_busy = (state_reg == dwdt_pkg::DWDT_LOW);

  // Pin is driven low exactly while in the low phase
  AST_LOW_DRIVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg == dwdt_pkg::DWDT_LOW) |-> (kick_oe && !kick_o)) else $error("kick not low");
  // Outside the low phase the pin is never pulled low
  AST_NO_LOW_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg != dwdt_pkg::DWDT_LOW) |-> !(kick_oe && !kick_o)) else $error("stray low");
  // Unbuffered use: released pin floats
  AST_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_reg == dwdt_pkg::DWDT_WAIT && !buffered_drive_high) |-> !kick_oe)
    else $error("pin not floating");
  // Low phase lasts the set time at least eight cycles
  AST_LOW_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(kick_busy) |-> kick_busy [*8]) else $error("low too short");
  // Pin reads back low while the kicker pulls it down
  AST_PIN_BACK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (kick_oe && !kick_o) |-> !kick_in) else $error("pin not low");
  COV_KICK: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(kick_busy));
endmodule

// file: src/dwdt_pkg.sv
package dwdt_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ = 25_000_000;
  // Recommended low time of one kick, in ms
  localparam int unsigned KICK_LOW_MS = 200;
  localparam int unsigned KICK_LOW_CYC = (CLK_HZ / 1000) * KICK_LOW_MS;
  // Shortest and longest configurable timeout, in seconds
  localparam int unsigned TIMEOUT_MIN_S = 30;
  localparam int unsigned TIMEOUT_MAX_S = 240;
  // Default kick period, safely below the shortest timeout, in seconds
  localparam int unsigned KICK_PERIOD_S = 20;
  // Expiry pulse length, in ms
  localparam int unsigned EXPIRY_PULSE_MS = 300;
  localparam int unsigned EXPIRY_PULSE_CYC = (CLK_HZ / 1000) * EXPIRY_PULSE_MS;
  // Width of the time counters
  localparam int unsigned CNT_W = 40;
  // Kicker states
  typedef enum logic [1:0] {
    DWDT_IDLE,
    DWDT_LOW,
    DWDT_WAIT
  } dwdt_kick_state_t;
endpackage
